// File: testbench/mapper_asserts.sv
// Checker on the mapper top ports.
// Assumes one clock and the synchronous reset of the top.
`timescale 1ns/1ps
`default_nettype none
module mapper_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tap_valid,
  input wire logic [7:0] tap_pos,
  input wire logic thr_write_start,
  input wire logic [7:0] wiper_code_ff,
  input wire logic code_valid_ff,
  input wire logic tap_error_ff,
  input wire logic write_busy_ff,
  input wire logic write_done_ff,
  input wire logic write_refused_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  seg_zero_a: assert property (tap_valid && tap_pos < 25 |=> code_valid_ff && wiper_code_ff == $past(tap_pos)) else $error("segment 0 code");
  seg_one_a: assert property (tap_valid && tap_pos inside {[25:49]} |=> wiper_code_ff == 8'h51 - $past(tap_pos)) else $error("segment 1 code");
  seg_two_a: assert property (tap_valid && tap_pos inside {[50:74]} |=> wiper_code_ff == $past(tap_pos) + 8'h0E) else $error("segment 2 code");
  seg_three_a: assert property (tap_valid && tap_pos inside {[75:99]} |=> wiper_code_ff == 8'hC3 - $past(tap_pos)) else $error("segment 3 code");
  valid_pulse_a: assert property (code_valid_ff |-> $past(tap_valid)) else $error("stray code valid");
  range_flag_a: assert property (tap_valid |=> tap_error_ff == ($past(tap_pos) > 8'h63)) else $error("range flag wrong");
  top_bit_a: assert property (wiper_code_ff[7] == 1'b0) else $error("bit 7 set");
  write_start_a: assert property (thr_write_start && !write_busy_ff |=> write_busy_ff) else $error("no busy");
  write_refuse_a: assert property (thr_write_start && write_busy_ff |=> write_refused_ff) else $error("no refusal");
  write_done_a: assert property ($fell(write_busy_ff) |-> write_done_ff) else $error("done missing");
endmodule : mapper_asserts
bind hundred_tap_wiper_code_mapper mapper_asserts chk (.clock(clock), .sys_rst(sys_rst),
  .tap_valid(tap_valid), .tap_pos(tap_pos), .thr_write_start(thr_write_start),
  .wiper_code_ff(wiper_code_ff), .code_valid_ff(code_valid_ff), .tap_error_ff(tap_error_ff),
  .write_busy_ff(write_busy_ff), .write_done_ff(write_done_ff),
  .write_refused_ff(write_refused_ff));
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the wiper code mapper.
// Assumes short write and gap counts; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [19:0] WCC = 20'h00014;
  logic clock = 0, sys_rst = 1, tap_valid = 0, start = 0, pin = 0;
  logic [7:0] tap_pos = 8'h00, held;
  logic [7:0] code;
  logic cv, te, busy, done, refused, gs, seen;
  int err_count = 0, tests_run = 0, k;
  always #5 clock = ~clock;
  hundred_tap_wiper_code_mapper #(.WRITE_CYCLE_COUNT(WCC), .GAP_COUNT(20'h0000A)) uut (
    .clock(clock), .sys_rst(sys_rst), .tap_valid(tap_valid), .tap_pos(tap_pos),
    .thr_write_start(start), .program_enable_pin(pin), .wiper_code_ff(code),
    .code_valid_ff(cv), .tap_error_ff(te), .write_busy_ff(busy), .write_done_ff(done),
    .write_refused_ff(refused), .gap_short_ff(gs));
  wiper_reg_model far (.clock(clock), .load(cv), .data(code), .held_ff(held));
  task chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task print_verdict;
    $display("Tests %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  function automatic logic [7:0] exp_code(input int t);
    int s;
    s = (t > 99) ? 99 : t;
    if (s < 25) return 8'(s);
    if (s < 50) return 8'(81 - s);
    if (s < 75) return 8'(s + 14);
    return 8'(195 - s);
  endfunction : exp_code
  // Back-to-back requests across every tap and past the top.
  task t_map;
    for (int t = 0; t < 106; t++) begin
      tap_pos = 8'(t);
      tap_valid = 1;
      @(negedge clock);
      chk(cv === 1'b1 && code === exp_code(t) && te === (t > 99), "tap code");
    end
    tap_valid = 0;
    @(negedge clock);
    chk(cv === 1'b0 && held === 8'h60, "held code");
    $display("map test done");
  endtask : t_map
  // Write cycle length with a refused start in mid-cycle.
  task t_write;
    start = 1;
    @(negedge clock);
    chk(busy === 1'b1, "busy");
    @(negedge clock);
    chk(refused === 1'b1, "refused");
    start = 0;
    k = 2;
    while (done !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    chk(k == WCC + 1 && busy === 1'b0, "write length");
    start = 1;
    @(negedge clock);
    start = 0;
    chk(busy === 1'b1 && refused === 1'b0, "start in done cycle");
    k = 1;
    while (done !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    chk(k == WCC + 1 && busy === 1'b0, "second length");
    $display("write test done");
  endtask : t_write
  task gap_try(input int low, output logic s);
    pin = 0;
    repeat (low) @(negedge clock);
    pin = 1;
    s = 0;
    repeat (8) begin
      @(negedge clock);
      if (gs === 1'b1) s = 1;
    end
  endtask : gap_try
  // Short and long enable-off gaps.
  task t_gap;
    gap_try(2, seen);
    chk(seen === 1'b0, "first rise");
    gap_try(3, seen);
    chk(seen === 1'b1, "short gap");
    gap_try(20, seen);
    chk(seen === 1'b0, "long gap");
    $display("gap test done");
  endtask : t_gap
  initial begin
    repeat (4) @(negedge clock);
    sys_rst = 0;
    t_map();
    t_write();
    t_gap();
    print_verdict();
  end
  initial begin
    #20000;
    err_count++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// File: testbench/wiper_reg_model.sv
// Far-side model: the wiper register that loads each translated byte.
// Assumes it shares the mapper clock and loads on code_valid_ff.
`timescale 1ns/1ps
`default_nettype none
module wiper_reg_model (
  input wire logic clock,
  input wire logic load,
  input wire logic [7:0] data,
  output logic [7:0] held_ff
);
  always_ff @(posedge clock) begin
    if (load) begin
      held_ff <= data;
    end
  end
endmodule : wiper_reg_model
`default_nettype wire

// File: verilog/hundred_tap_wiper_code_mapper.sv
// Top of the wiper code mapper: registers the translated byte, times threshold
// writes and watches the program-enable off gap between adjustments.
// Assumes tap requests and write starts come from logic on the same clock; the
// program-enable level is a pin and is synchronised here.
// The write and gap counts are parameters so a bench can shorten them.
// No registers are reachable by software; all results leave as ports.
`timescale 1ns/1ps
`default_nettype none
module hundred_tap_wiper_code_mapper #(
  parameter logic [19:0] WRITE_CYCLE_COUNT = tap_mapper_pkg::WRITE_CYCLE_COUNT,
  parameter logic [19:0] GAP_COUNT = tap_mapper_pkg::GAP_COUNT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tap_valid,
  input wire logic [7:0] tap_pos,
  input wire logic thr_write_start,
  input wire logic program_enable_pin,
  output logic [7:0] wiper_code_ff,
  output logic code_valid_ff,
  output logic tap_error_ff,
  output logic write_busy_ff,
  output logic write_done_ff,
  output logic write_refused_ff,
  output logic gap_short_ff
);
  // Two states suffice: the count alone tells how far a write has gone.
  typedef enum logic [0:0] {
    write_idle,
    write_active
  } write_state_type;

  // Ten millisecond ceiling.
  // A longer count from the parameter is cut back so no write overruns the limit.
  localparam logic [19:0] WRITE_LEN =
    (WRITE_CYCLE_COUNT > tap_mapper_pkg::WRITE_CYCLE_LIMIT) ?
    tap_mapper_pkg::WRITE_CYCLE_LIMIT : WRITE_CYCLE_COUNT;

  // Segment arithmetic is combinational; only the registered result leaves here.
  tap_code_if code_bus ();

  tap_segment_encoder encoder_u (
    .enc(code_bus)
  );

  assign code_bus.tap = tap_pos;

  logic [7:0] nxt_wiper_code;
  logic nxt_code_valid;
  logic nxt_tap_error;

  // The byte is only updated on a request so the wiper path sees a stable value.
  // An out-of-range tap still loads the saturated code, flagged alongside it.
  always_comb begin
    nxt_wiper_code = wiper_code_ff;
    nxt_code_valid = 1'b0;
    nxt_tap_error = 1'b0;
    if (tap_valid) begin
      nxt_wiper_code = code_bus.code;
      nxt_code_valid = 1'b1;
      nxt_tap_error = code_bus.range_error;
    end
  end

  // Valid and error are pulses; the byte itself stands until the next request.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wiper_code_ff <= 8'h00;
      code_valid_ff <= 1'b0;
      tap_error_ff <= 1'b0;
    end else begin
      wiper_code_ff <= nxt_wiper_code;
      code_valid_ff <= nxt_code_valid;
      tap_error_ff <= nxt_tap_error;
    end
  end

  logic enable_meta_ff;
  logic enable_sync_ff;
  logic enable_prev_ff;
  logic nxt_enable_meta;
  logic nxt_enable_sync;
  logic nxt_enable_prev;

  // The enable is a pin: two flops settle it before any logic reads it.
  // The third flop keeps the last settled value so a rise can be seen.
  // Nothing but the second flop reads the first.
  always_comb begin
    nxt_enable_meta = program_enable_pin;
    nxt_enable_sync = enable_meta_ff;
    nxt_enable_prev = enable_sync_ff;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable_meta_ff <= 1'b0;
      enable_sync_ff <= 1'b0;
      enable_prev_ff <= 1'b0;
    end else begin
      enable_meta_ff <= nxt_enable_meta;
      enable_sync_ff <= nxt_enable_sync;
      enable_prev_ff <= nxt_enable_prev;
    end
  end

  logic [19:0] gap_cnt_ff;
  logic [19:0] nxt_gap_cnt;
  logic gap_done_ff;
  logic nxt_gap_done;
  logic nxt_gap_short;
  logic enable_rise;

  assign enable_rise = enable_sync_ff && !enable_prev_ff;

  // The gap is the controller's duty; the block only reports a short one,
  // it cannot stop the analogue programming pulse itself.
  always_comb begin
    nxt_gap_cnt = gap_cnt_ff;
    nxt_gap_done = gap_done_ff;
    nxt_gap_short = 1'b0;
    if (enable_sync_ff) begin
      nxt_gap_cnt = 20'h00000;
      if (enable_rise && !gap_done_ff) begin
        nxt_gap_short = 1'b1;
      end
      nxt_gap_done = 1'b0;
    end else if (!gap_done_ff) begin
      nxt_gap_cnt = gap_cnt_ff + 20'h00001;
      if (nxt_gap_cnt >= GAP_COUNT) begin
        nxt_gap_done = 1'b1;
      end
    end
  end

  // Reset counts the gap as kept, so the first enable after reset is not flagged.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gap_cnt_ff <= 20'h00000;
      gap_done_ff <= 1'b1;
      gap_short_ff <= 1'b0;
    end else begin
      gap_cnt_ff <= nxt_gap_cnt;
      gap_done_ff <= nxt_gap_done;
      gap_short_ff <= nxt_gap_short;
    end
  end

  write_state_type write_state_ff;
  write_state_type nxt_write_state;
  logic [19:0] write_cnt_ff;
  logic [19:0] nxt_write_cnt;
  logic nxt_write_busy;
  logic nxt_write_done;
  logic nxt_write_refused;

  // A start while busy is refused, not queued: the cell is still writing and a
  // second operation on it would be lost.
  always_comb begin
    nxt_write_state = write_state_ff;
    nxt_write_cnt = write_cnt_ff;
    nxt_write_busy = write_busy_ff;
    nxt_write_done = 1'b0;
    nxt_write_refused = 1'b0;
    case (write_state_ff)
      write_idle: begin
        if (thr_write_start) begin
          nxt_write_state = write_active;
          nxt_write_cnt = 20'h00000;
          nxt_write_busy = 1'b1;
        end
      end
      write_active: begin
        if (thr_write_start) begin
          nxt_write_refused = 1'b1;
        end
        nxt_write_cnt = write_cnt_ff + 20'h00001;
        if (nxt_write_cnt >= WRITE_LEN) begin
          nxt_write_state = write_idle;
          nxt_write_busy = 1'b0;
          nxt_write_done = 1'b1;
        end
      end
      default: begin
        nxt_write_state = write_idle;
        nxt_write_cnt = 20'h00000;
        nxt_write_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_state_ff <= write_idle;
      write_cnt_ff <= 20'h00000;
      write_busy_ff <= 1'b0;
      write_done_ff <= 1'b0;
      write_refused_ff <= 1'b0;
    end else begin
      write_state_ff <= nxt_write_state;
      write_cnt_ff <= nxt_write_cnt;
      write_busy_ff <= nxt_write_busy;
      write_done_ff <= nxt_write_done;
      write_refused_ff <= nxt_write_refused;
    end
  end
endmodule : hundred_tap_wiper_code_mapper
`default_nettype wire

// File: verilog/tap_code_if.sv
// Carrier between the mapper top and its segment encoder.
// Assumes both ends sit in one clock domain; the path is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface tap_code_if;
  logic [7:0] tap;
  logic [7:0] code;
  logic range_error;
  modport encoder (input tap, output code, output range_error);
  modport user (output tap, input code, input range_error);
endinterface : tap_code_if
`default_nettype wire

// File: verilog/tap_mapper_pkg.sv
// Constants for the hundred-tap wiper code mapper and its threshold write timing.
// Assumes a single 100 MHz clock; all counts are derived here from printed times.
package tap_mapper_pkg;
  localparam logic [7:0] TAP_MAX = 8'h63;
  localparam logic [7:0] SEG_SIZE = 8'h19;
  localparam logic [7:0] SEG1_BASE = 8'h51;
  localparam logic [7:0] SEG2_ADD = 8'h0E;
  localparam logic [7:0] SEG3_BASE = 8'hC3;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WRITE_CYCLE_TYP_US = 5000;
  localparam int unsigned WRITE_CYCLE_MAX_US = 10000;
  localparam int unsigned GAP_MIN_US = 1000;
  localparam int unsigned CNT_W = 20;
  localparam logic [19:0] WRITE_CYCLE_COUNT = 20'(WRITE_CYCLE_TYP_US * CLK_MHZ);
  localparam logic [19:0] WRITE_CYCLE_LIMIT = 20'(WRITE_CYCLE_MAX_US * CLK_MHZ);
  localparam logic [19:0] GAP_COUNT = 20'(GAP_MIN_US * CLK_MHZ);
endpackage : tap_mapper_pkg

// File: verilog/tap_segment_encoder.sv
// Combinational translation of a tap index to its wiper data byte.
// Assumes the caller registers the result; no state is held here.
`timescale 1ns/1ps
`default_nettype none
module tap_segment_encoder (
  tap_code_if.encoder enc
);
  logic [7:0] tap_sat;
  logic [7:0] quot;
  logic [7:0] raw;
  logic [1:0] seg;

  always_comb begin
    tap_sat = enc.tap;
    enc.range_error = 1'b0;
    if (enc.tap > tap_mapper_pkg::TAP_MAX) begin
      tap_sat = tap_mapper_pkg::TAP_MAX;
      enc.range_error = 1'b1;
    end
    quot = tap_sat / tap_mapper_pkg::SEG_SIZE;
    seg = quot[1:0];
    case (seg)
      2'h0: raw = tap_sat;
      2'h1: raw = tap_mapper_pkg::SEG1_BASE - tap_sat;
      2'h2: raw = tap_sat + tap_mapper_pkg::SEG2_ADD;
      2'h3: raw = tap_mapper_pkg::SEG3_BASE - tap_sat;
      default: raw = 8'h00;
    endcase
    enc.code = {1'b0, raw[6:0]};
  end
endmodule : tap_segment_encoder
`default_nettype wire
